// >>> rtl/port_mode_config.sv
`timescale 1ns/10ps

module port_mode_config
  import port_mode_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // Host register access, one-cycle strobes from the bus interface.
  input  wire logic             io_sel_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             wr_stb_i,
  input  wire logic             rd_stb_i,
  input  wire logic [7:0]       wr_data_i,
  output logic      [7:0]       rd_data_o,
  // Host bus shape and address capture.
  input  wire host_bus_t        host_bus_i,
  input  wire logic             data_port_cfg_i,
  input  wire logic [15:0]      host_addr_i,
  input  wire logic             address_latch_strobe_i,
  input  wire logic [7:0]       host_data_i,
  input  wire logic             host_rd_i,
  output logic      [7:0]       host_data_o,
  output logic                  host_data_oe_o,
  // Programmable-logic terms per port (A, B, C, D).
  input  wire logic [4*W-1:0]   plogic_out_i,
  input  wire logic [4*W-1:0]   plogic_oe_i,
  input  wire logic [4*W-1:0]   data_out_i,
  input  wire logic [4*W-1:0]   addr_in_sel_i,
  input  wire logic             peripheral_select_a_i,
  input  wire logic             peripheral_select_b_i,
  input  wire logic             test_port_select_term_i,
  input  wire logic             test_port_cfg_i,
  input  wire logic             test_port_enable_i,
  input  wire logic [4*W-1:0]   pin_i,
  output pin_drive_t            port_a_o,
  output pin_drive_t            port_b_o,
  output pin_drive_t            port_c_o,
  output pin_drive_t            port_d_o,
  output logic      [4*W-1:0]   input_macrocell_o,
  output logic                  test_port_en_o
);

  port_cfg_t  cfg_a_q;
  port_cfg_t  cfg_b_q;
  port_cfg_t  cfg_c_q;
  port_cfg_t  cfg_d_q;
  logic [7:0] periph_q;
  logic [4*W-1:0] pin_s1_q;
  logic [4*W-1:0] pin_s2_q;
  logic [4*W-1:0] pin_s3_q;
  logic [4*W-1:0] pin_f_q;
  logic [2:0] strobe_sync_q;
  logic       strobe_f_q;
  logic [7:0] lat_lo_q;
  logic [7:0] lat_hi_q;
  logic       wr_hit;

  assign wr_hit = io_sel_i & wr_stb_i;

  // Register writes update in the same edge the write strobe is taken, so a pin
  // changes mode the cycle after the host write with no extra settling stage.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_a_q <= '{CFG_RESET, CFG_RESET, CFG_RESET};
    end else if (wr_hit) begin
      if (reg_addr_i == OFS_FSEL_A) begin
        cfg_a_q.fsel <= wr_data_i;
      end
      if (reg_addr_i == OFS_DIR_A) begin
        cfg_a_q.dir <= wr_data_i;
      end
      if (reg_addr_i == OFS_DRV_A) begin
        cfg_a_q.drv <= wr_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_b_q <= '{CFG_RESET, CFG_RESET, CFG_RESET};
    end else if (wr_hit) begin
      if (reg_addr_i == OFS_FSEL_B) begin
        cfg_b_q.fsel <= wr_data_i;
      end
      if (reg_addr_i == OFS_DIR_B) begin
        cfg_b_q.dir <= wr_data_i;
      end
      if (reg_addr_i == OFS_DRV_B) begin
        cfg_b_q.drv <= wr_data_i;
      end
    end
  end

  // Ports C and D have no select register; their select field stays zero for good.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_c_q <= '{CFG_RESET, CFG_RESET, CFG_RESET};
    end else if (wr_hit) begin
      if (reg_addr_i == OFS_DIR_C) begin
        cfg_c_q.dir <= wr_data_i;
      end
      if (reg_addr_i == OFS_DRV_C) begin
        cfg_c_q.drv <= wr_data_i;
      end
    end
  end

  // Port D has three pins, so the upper bits are dropped at the write.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_d_q <= '{CFG_RESET, CFG_RESET, CFG_RESET};
    end else if (wr_hit) begin
      if (reg_addr_i == OFS_DIR_D) begin
        cfg_d_q.dir <= wr_data_i & PORT_D_MASK;
      end
      if (reg_addr_i == OFS_DRV_D) begin
        cfg_d_q.drv <= wr_data_i & PORT_D_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periph_q <= CFG_RESET;
    end else if (wr_hit && reg_addr_i == OFS_PERIPH) begin
      periph_q <= wr_data_i;
    end
  end

  // Read data is registered; unmapped offsets and the absent select registers read zero.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (io_sel_i && rd_stb_i) begin
      unique case (reg_addr_i)
        OFS_FSEL_A: rd_data_o <= cfg_a_q.fsel;
        OFS_FSEL_B: rd_data_o <= cfg_b_q.fsel;
        OFS_DIR_A:  rd_data_o <= cfg_a_q.dir;
        OFS_DIR_B:  rd_data_o <= cfg_b_q.dir;
        OFS_DIR_C:  rd_data_o <= cfg_c_q.dir;
        OFS_DIR_D:  rd_data_o <= cfg_d_q.dir;
        OFS_DRV_A:  rd_data_o <= cfg_a_q.drv;
        OFS_DRV_B:  rd_data_o <= cfg_b_q.drv;
        OFS_DRV_C:  rd_data_o <= cfg_c_q.drv;
        OFS_DRV_D:  rd_data_o <= cfg_d_q.drv;
        OFS_PERIPH: rd_data_o <= periph_q;
        default:    rd_data_o <= 8'h00;
      endcase
    end
  end

  // Pins come from outside; three stages, and a change is taken once two agree.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_q      <= '0;
      pin_s2_q      <= '0;
      pin_s3_q      <= '0;
      pin_f_q       <= '0;
      strobe_sync_q <= 3'h0;
      strobe_f_q    <= 1'b0;
    end else begin
      pin_s1_q      <= pin_i;
      pin_s2_q      <= pin_s1_q;
      pin_s3_q      <= pin_s2_q;
      pin_f_q       <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q | pin_s3_q));
      strobe_sync_q <= {strobe_sync_q[1:0], address_latch_strobe_i};
      if (strobe_sync_q[1] == strobe_sync_q[2]) begin
        strobe_f_q <= strobe_sync_q[2];
      end
    end
  end

  // Address-in capture on the falling strobe, only for pins the decode uses.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_macrocell_o <= '0;
    end else begin
      for (int i = 0; i < 4*W; i++) begin
        if (strobe_f_q && (strobe_sync_q[1] == strobe_sync_q[2]) && !strobe_sync_q[2]
            && addr_in_sel_i[i]) begin
          input_macrocell_o[i] <= pin_f_q[i];
        end else if (!addr_in_sel_i[i]) begin
          input_macrocell_o[i] <= pin_f_q[i];
        end
      end
    end
  end

  // Except in HOST_NON_MUX, where it is loaded every cycle, the host address is latched on the strobe so it stays valid through the data phase.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_lo_q <= 8'h00;
      lat_hi_q <= 8'h00;
    end else if (address_latch_strobe_i || host_bus_i == HOST_NON_MUX) begin
      lat_lo_q <= host_addr_i[7:0];
      lat_hi_q <= host_addr_i[15:8];
    end
  end

  function automatic pin_drive_t drive_pins(
    input logic [7:0] src,
    input logic [7:0] oe,
    input logic [7:0] od_mask,
    input logic [7:0] drv
  );
    pin_drive_t p;
    p.out        = src;
    p.oe         = oe;
    p.open_drain = drv & od_mask;
    p.fast_slew  = drv & ~od_mask;
    return p;
  endfunction : drive_pins

  logic [7:0] addr_a;
  logic [7:0] addr_b;
  logic [7:0] aen_a;
  logic [7:0] aen_b;
  logic [7:0] oe_a, oe_b, oe_c, oe_d;
  logic [7:0] src_a, src_b, src_c, src_d;
  logic [7:0] lt_oe [4];
  logic       periph_mode;
  logic       periph_sel;

  // Latched address nibble placement depends on the host bus shape.
  always_comb begin
    addr_a = {lat_lo_q[7:4], lat_lo_q[3:0]};
    addr_b = {lat_lo_q[7:4], lat_lo_q[3:0]};
    aen_a  = 8'hFF;
    aen_b  = 8'hFF;
    unique case (host_bus_i)
      HOST_GENERIC_MUX: ;
      HOST_WIDE_ADDR: begin
        aen_a  = HI_NIB_MASK;
        addr_b = {4'h0, lat_hi_q[3:0]};
        aen_b  = LO_NIB_MASK;
      end
      HOST_PAGE_MODE: begin
        aen_a  = 8'h00;
        addr_b = lat_hi_q;
      end
      HOST_NON_MUX: aen_a = 8'h00;
    endcase
  end

  assign periph_mode = periph_q[PERIPH_BIT] & ~data_port_cfg_i;
  assign periph_sel  = peripheral_select_a_i | peripheral_select_b_i;

  for (genvar p = 0; p < 4; p++) begin : g_oe
    assign lt_oe[p] = plogic_oe_i[p*W +: 8];
  end

  // Port A: the data port and the peripheral buffer take the whole port over.
  always_comb begin
    // the pin drives when direction or logic enable is 1.
    oe_a = cfg_a_q.dir | lt_oe[0];
    for (int i = 0; i < 8; i++) begin
      // address out needs the select bit and the bus-shape address enable.
      src_a[i] = (cfg_a_q.fsel[i] & aen_a[i]) ? addr_a[i]
               : (lt_oe[0][i] ? plogic_out_i[i] : data_out_i[i]);
    end
    if (data_port_cfg_i) begin
      src_a = host_data_i;
      oe_a  = {8{host_rd_i}};
    end else if (periph_mode) begin
      src_a = host_data_i;
      oe_a  = {8{periph_sel & ~host_rd_i}};
    end
  end

  // Port B carries address out but has no data port or buffer mode.
  always_comb begin
    oe_b = cfg_b_q.dir | lt_oe[1];
    for (int i = 0; i < 8; i++) begin
      src_b[i] = (cfg_b_q.fsel[i] & aen_b[i]) ? addr_b[i]
               : (lt_oe[1][i] ? plogic_out_i[W+i] : data_out_i[W+i]);
    end
  end

  // Ports C and D never carry address out, so only the logic enable steers the source.
  // A plain OR of the two sources would let output data corrupt a logic output.
  always_comb begin
    oe_c  = cfg_c_q.dir | lt_oe[2];
    oe_d  = (cfg_d_q.dir | lt_oe[3]) & PORT_D_MASK;
    src_c = (plogic_out_i[2*W +: 8] & lt_oe[2])
          | (data_out_i[2*W +: 8] & ~lt_oe[2]);
    src_d = (plogic_out_i[3*W +: 8] & lt_oe[3])
          | (data_out_i[3*W +: 8] & ~lt_oe[3]);
  end

  // Host-facing data path for data port and peripheral buffer reads.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_data_o <= 8'h00;
    end else begin
      host_data_o <= pin_f_q[7:0];
    end
  end

  assign host_data_oe_o = host_rd_i & (data_port_cfg_i | (periph_mode & periph_sel));

  always_comb begin
    port_a_o = drive_pins(src_a, oe_a, HI_NIB_MASK, cfg_a_q.drv);
    port_b_o = drive_pins(src_b, oe_b, HI_NIB_MASK, cfg_b_q.drv);
    port_c_o = drive_pins(src_c, oe_c, 8'hFF, cfg_c_q.drv);
    port_d_o = drive_pins(src_d, oe_d, 8'h00, cfg_d_q.drv);
  end

  assign test_port_en_o = test_port_select_term_i | test_port_cfg_i | test_port_enable_i;

endmodule : port_mode_config

// >>> rtl/port_mode_pkg.sv
package port_mode_pkg;

  // Register offsets within the I/O register block. The block decodes the low address byte.
  localparam logic [7:0] OFS_FSEL_A  = 8'h02;
  localparam logic [7:0] OFS_FSEL_B  = 8'h03;
  localparam logic [7:0] OFS_DIR_A   = 8'h06;
  localparam logic [7:0] OFS_DIR_B   = 8'h07;
  localparam logic [7:0] OFS_DIR_C   = 8'h12;
  localparam logic [7:0] OFS_DIR_D   = 8'h13;
  localparam logic [7:0] OFS_DRV_A   = 8'h08;
  localparam logic [7:0] OFS_DRV_B   = 8'h09;
  localparam logic [7:0] OFS_DRV_C   = 8'h14;
  localparam logic [7:0] OFS_DRV_D   = 8'h15;
  localparam logic [7:0] OFS_PERIPH  = 8'h2C;

  localparam logic [7:0] CFG_RESET   = 8'h00;
  localparam int         PERIPH_BIT  = 7;
  localparam logic [7:0] PORT_D_MASK = 8'h07;
  localparam logic [7:0] HI_NIB_MASK = 8'hF0;
  localparam logic [7:0] LO_NIB_MASK = 8'h0F;

  typedef enum logic [1:0] {
    HOST_GENERIC_MUX,
    HOST_WIDE_ADDR,
    HOST_PAGE_MODE,
    HOST_NON_MUX
  } host_bus_t;

  typedef struct packed {
    logic [7:0] fsel;
    logic [7:0] dir;
    logic [7:0] drv;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] open_drain;
    logic [7:0] fast_slew;
  } pin_drive_t;

endpackage : port_mode_pkg

// >>> tb/port_mode_checker.sv
`timescale 1ns/10ps
module port_mode_checker
  import port_mode_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic           sys_clk_i,
  input wire logic           rst_n_i,
  input wire logic           io_sel_i,
  input wire logic [7:0]     reg_addr_i,
  input wire logic           wr_stb_i,
  input wire logic           rd_stb_i,
  input wire logic [7:0]     wr_data_i,
  input wire logic [7:0]     rd_data_o,
  input wire logic [4*W-1:0] plogic_oe_i,
  input wire logic           test_port_select_term_i,
  input wire logic           test_port_cfg_i,
  input wire logic           test_port_enable_i,
  input wire pin_drive_t     port_a_o,
  input wire pin_drive_t     port_c_o,
  input wire pin_drive_t     port_d_o,
  input wire logic           test_port_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence cfg_wr(logic [7:0] a); io_sel_i && wr_stb_i && reg_addr_i == a; endsequence
  sequence cfg_rd(logic [7:0] a); io_sel_i && rd_stb_i && reg_addr_i == a; endsequence
  slew_port_a_a: assert property (
    cfg_wr(OFS_DRV_A) |=> port_a_o.fast_slew == ($past(wr_data_i) & LO_NIB_MASK))
    else $error("port a slew mismatch");
  drain_port_a_a: assert property (
    cfg_wr(OFS_DRV_A) |=> port_a_o.open_drain == ($past(wr_data_i) & HI_NIB_MASK))
    else $error("port a drain mismatch");
  drain_port_c_a: assert property (
    cfg_wr(OFS_DRV_C) |=> port_c_o.open_drain == $past(wr_data_i) && port_c_o.fast_slew == 8'h00)
    else $error("port c drive mismatch");
  slew_port_d_a: assert property (
    cfg_wr(OFS_DRV_D) |=> port_d_o.fast_slew == ($past(wr_data_i) & PORT_D_MASK))
    else $error("port d slew mismatch");
  dir_port_c_a: assert property (
    cfg_wr(OFS_DIR_C) ##1 (plogic_oe_i[23:16] == 8'h00 && !test_port_en_o)
    |-> port_c_o.oe == $past(wr_data_i)) else $error("port c enable mismatch");
  dir_port_d_a: assert property (
    cfg_wr(OFS_DIR_D) ##1 plogic_oe_i[31:24] == 8'h00
    |-> port_d_o.oe == ($past(wr_data_i) & PORT_D_MASK)) else $error("port d enable mismatch");
  unmapped_read_a: assert property (
    cfg_rd(8'hFF) |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
  read_hold_a: assert property (
    !(io_sel_i && rd_stb_i) |=> $stable(rd_data_o)) else $error("read data moved");
  test_enable_a: assert property (
    test_port_en_o == (test_port_select_term_i || test_port_cfg_i || test_port_enable_i))
    else $error("test port enable mismatch");
endmodule : port_mode_checker
bind port_mode_config port_mode_checker #(.W(W)) u_chk (.*);

// >>> tb/pin_far_side.sv
`timescale 1ns/10ps
module pin_far_side
  import port_mode_pkg::*;
(
  input  wire pin_drive_t  port_a_i,
  input  wire pin_drive_t  port_b_i,
  input  wire pin_drive_t  port_c_i,
  input  wire pin_drive_t  port_d_i,
  input  wire logic [31:0] ext_i,
  output logic      [31:0] pin_o
);
  logic [31:0] oe;
  // Released pins show the ext_i pattern, which changes every cycle except while the testbench holds it.
  assign oe    = {port_d_i.oe, port_c_i.oe, port_b_i.oe, port_a_i.oe};
  assign pin_o = ({port_d_i.out, port_c_i.out, port_b_i.out, port_a_i.out} & oe)
               | (ext_i & ~oe);
endmodule : pin_far_side

// >>> tb/tb_mcu_port_mode_config.sv
`timescale 1ns/10ps
module tb_mcu_port_mode_config
  import port_mode_pkg::*;
;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, io_sel_i = 1'b0, wr_stb_i = 1'b0, rd_stb_i = 1'b0;
  logic address_latch_strobe_i = 1'b0, data_port_cfg_i = 1'b0, host_rd_i = 1'b0;
  logic peripheral_select_a_i = 1'b0, peripheral_select_b_i = 1'b0;
  logic test_port_select_term_i = 1'b0, test_port_cfg_i = 1'b0, test_port_enable_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00, wr_data_i = 8'h00, host_data_i = 8'h00, rd_data_o, host_data_o;
  logic        host_data_oe_o, test_port_en_o;
  host_bus_t   host_bus_i = HOST_GENERIC_MUX;
  logic [15:0] host_addr_i = 16'h0000, a;
  logic [31:0] plogic_out_i = '0, plogic_oe_i = '0, data_out_i = '0, addr_in_sel_i = '0;
  logic [31:0] ext_pins = '0, pin_i, input_macrocell_o, e;
  pin_drive_t  port_a_o, port_b_o, port_c_o, port_d_o;
  logic [7:0]  v, ofs [10];
  int          errors = 0, checked = 0, seed = 45;
  logic        ext_hold = 1'b0;

  port_mode_config #(.W(8)) u_dut (.*);
  pin_far_side u_far (.port_a_i(port_a_o), .port_b_i(port_b_o), .port_c_i(port_c_o),
                      .port_d_i(port_d_o), .ext_i(ext_pins), .pin_o(pin_i));

  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(negedge sys_clk_i) if (!ext_hold) ext_pins <= $random(seed);

  function automatic logic [7:0] msk(logic [7:0] o);
    return (o == OFS_DIR_D || o == OFS_DRV_D) ? PORT_D_MASK : 8'hFF;
  endfunction : msk
  // Packs {port b mask, port b address, port a mask, port a address}.
  function automatic logic [31:0] adr_exp(host_bus_t b, logic [15:0] x);
    case (b)
      HOST_WIDE_ADDR: return {8'h0F, 4'h0, x[11:8], 8'hF0, x[7:0]};
      HOST_PAGE_MODE: return {8'hFF, x[15:8], 16'h0000};
      HOST_NON_MUX:   return {8'hFF, x[7:0], 16'h0000};
      default:        return {8'hFF, x[7:0], 8'hFF, x[7:0]};
    endcase
  endfunction : adr_exp
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    @(negedge sys_clk_i); io_sel_i = 1'b1; wr_stb_i = 1'b1; reg_addr_i = o; wr_data_i = d;
    @(negedge sys_clk_i); io_sel_i = 1'b0; wr_stb_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] o, input logic [7:0] x);
    @(negedge sys_clk_i); io_sel_i = 1'b1; rd_stb_i = 1'b1; reg_addr_i = o;
    @(negedge sys_clk_i); io_sel_i = 1'b0; rd_stb_i = 1'b0;
    chk("rd_data_o", x, rd_data_o);
  endtask : rd
  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    conclude();
  end

  initial begin
    ofs = '{OFS_FSEL_A, OFS_FSEL_B, OFS_DIR_A, OFS_DIR_B, OFS_DIR_C, OFS_DIR_D,
            OFS_DRV_A, OFS_DRV_B, OFS_DRV_C, OFS_DRV_D};
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    foreach (ofs[i]) rd(ofs[i], 8'h00);
    chk("port_a_o.oe", 8'h00, port_a_o.oe);
    foreach (ofs[i]) begin
      v = 8'($random(seed));
      wr(ofs[i], v);
      rd(ofs[i], v & msk(ofs[i]));
    end
    wr(8'hFF, 8'hA5);
    rd(8'hFF, 8'h00);
    @(negedge sys_clk_i); rst_n_i = 1'b0;
    @(negedge sys_clk_i); rst_n_i = 1'b1;
    rd(OFS_DIR_A, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 4; i++) wr(ofs[i], 8'hFF);
    for (int k = 0; k < 12; k++) begin
      host_bus_i = host_bus_t'(k % 4);
      a = 16'($random(seed));
      host_addr_i = a;
      @(negedge sys_clk_i); address_latch_strobe_i = 1'b1;
      @(negedge sys_clk_i); address_latch_strobe_i = 1'b0;
      if (host_bus_i != HOST_NON_MUX) host_addr_i = ~a;
      repeat (2) @(negedge sys_clk_i);
      e = adr_exp(host_bus_i, a);
      chk("port_a_o.out", e[7:0] & e[15:8], port_a_o.out & e[15:8]);
      chk("port_b_o.out", e[23:16] & e[31:24], port_b_o.out & e[31:24]);
    end
    host_bus_i = HOST_GENERIC_MUX;
    $display("test address out done");
    wr(OFS_FSEL_A, 8'h00);
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 8'h00 : 8'($random(seed));
      plogic_oe_i[7:0] = (k == 0) ? 8'h00 : 8'($random(seed));
      data_out_i = $random(seed);
      wr(OFS_DIR_A, v);
      chk("port_a_o.oe", v | plogic_oe_i[7:0], port_a_o.oe);
      e[7:0] = v & ~plogic_oe_i[7:0];
      chk("port_a_o.out", data_out_i[7:0] & e[7:0], port_a_o.out & e[7:0]);
    end
    plogic_oe_i = '0;
    $display("test host io done");
    wr(OFS_DIR_A, 8'h00);
    ext_hold = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    v = ext_pins[7:0];
    chk("input_macrocell_o", v, input_macrocell_o[7:0]);
    chk("host_data_o", v, host_data_o);
    addr_in_sel_i[7:0] = 8'hFF;
    ext_hold = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    ext_hold = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    chk("input_macrocell_o", v, input_macrocell_o[7:0]);
    address_latch_strobe_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    address_latch_strobe_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    chk("input_macrocell_o", ext_pins[7:0], input_macrocell_o[7:0]);
    addr_in_sel_i = '0;
    ext_hold = 1'b0;
    $display("test address in done");
    wr(OFS_DIR_A, 8'hFF);
    wr(OFS_PERIPH, 8'h80);
    @(negedge sys_clk_i);
    chk("port_a_o.oe", 8'h00, port_a_o.oe);
    peripheral_select_b_i = 1'b1;
    host_data_i = 8'($random(seed));
    @(negedge sys_clk_i);
    chk("port_a_o.oe", 8'hFF, port_a_o.oe);
    chk("port_a_o.out", host_data_i, port_a_o.out);
    chk("host_data_oe_o", 1'b0, host_data_oe_o);
    host_rd_i = 1'b1;
    @(negedge sys_clk_i);
    chk("host_data_oe_o", 1'b1, host_data_oe_o);
    chk("port_a_o.oe", 8'h00, port_a_o.oe);
    data_port_cfg_i = 1'b1;
    @(negedge sys_clk_i);
    chk("port_a_o.out", host_data_i, port_a_o.out);
    chk("host_data_oe_o", 1'b1, host_data_oe_o);
    host_rd_i = 1'b0;
    data_port_cfg_i = 1'b0;
    peripheral_select_b_i = 1'b0;
    wr(OFS_PERIPH, 8'h00);
    $display("test peripheral done");
    for (int k = 0; k < 8; k++) begin
      {test_port_select_term_i, test_port_cfg_i, test_port_enable_i} = 3'(k);
      @(negedge sys_clk_i);
      chk("test_port_en_o", k != 0, test_port_en_o);
    end
    $display("test port select done");
    conclude();
  end
endmodule : tb_mcu_port_mode_config
